// ### hdl/nvsram_host_pkg.sv
// Constants, encodings and carrier types for the host-side controller
// of a byte-wide nonvolatile SRAM.
// Assumes a single 40 MHz clock; access time is turned into cycles here, long waits stay in us.
package nvsram_host_pkg;

   // Clock rate and derived microsecond divider
   localparam int MCLK_KHZ = 40000;
   localparam int CYC_PER_US = MCLK_KHZ / 1000;

   // Widths of the memory pins
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;

   // Chip-enable low time per access: slowest grade, rounded up to cycles
   localparam int ACCESS_NS = 45;
   localparam int STROBE_CYC = (ACCESS_NS * MCLK_KHZ + 999999) / 1000000;
   localparam logic [1:0] STROBE_LAST = 2'(STROBE_CYC - 1);

   // Durations in microseconds as given for the device
   localparam int NV_SAVE_DURATION_US = 10000;
   localparam int POWERUP_RELOAD_DURATION_US = 550;
   localparam int RECALL_DURATION_US = 20;
   localparam int PENDING_ACCESS_GRACE_US = 1;
   localparam int TMR_W = 16;
   localparam logic [TMR_W-1:0] RECALL_US = TMR_W'(RECALL_DURATION_US);

   // Six-step address sequence; only the last address differs
   localparam logic [ADDR_W-1:0] SEQ_A0 = 13'h0000;
   localparam logic [ADDR_W-1:0] SEQ_A1 = 13'h1555;
   localparam logic [ADDR_W-1:0] SEQ_A2 = 13'h0AAA;
   localparam logic [ADDR_W-1:0] SEQ_A3 = 13'h1FFF;
   localparam logic [ADDR_W-1:0] SEQ_A4 = 13'h10F0;
   localparam logic [ADDR_W-1:0] SEQ_STORE = 13'h0F0F;
   localparam logic [ADDR_W-1:0] SEQ_RECALL = 13'h0F0E;
   localparam logic [2:0] SEQ_LAST = 3'h5;

   // Values after reset
   localparam logic [7:0] RDATA_RST = 8'h00;

   // Host command codes
   typedef enum logic [1:0] {
      OP_READ = 2'h0,
      OP_WRITE = 2'h1,
      OP_STORE = 2'h2,
      OP_RECALL = 2'h3
   } op_t;

   // Controller states, Gray coded along the access path
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SETUP = 3'h1,
      ST_STROBE = 3'h3,
      ST_RECOVER = 3'h2,
      ST_NVWAIT = 3'h6,
      ST_PWR_OFF = 3'h7,
      ST_PWR_UP = 3'h5
   } state_t;

   // Memory strobes and address as driven to the device
   typedef struct packed {
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic [ADDR_W-1:0] addr_bus;
   } pin_t;

   // One request from the user side
   typedef struct packed {
      op_t op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } req_t;

   localparam pin_t PIN_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr_bus: 13'h0000};

endpackage

// ### hdl/us_timer.sv
// Microsecond-based down counter used for the long waits of the controller.
// Assumes one clock; start restarts the divider so the first tick is a full us.
`timescale 1ns/1ps

module us_timer #(
   parameter int CYC_PER_US = nvsram_host_pkg::CYC_PER_US,
   parameter int TMR_W = nvsram_host_pkg::TMR_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Control
   input wire logic start,
   input wire logic [TMR_W-1:0] load_us,
   // Status
   output logic done,
   output logic running
);

   typedef struct packed {
      logic [7:0] div;
      logic [TMR_W-1:0] cnt;
      logic run;
      logic done;
   } tmr_st_t;

   localparam logic [7:0] DIV_LAST = 8'(CYC_PER_US - 1);

   tmr_st_t q, d;

   // A load of zero still waits one whole microsecond
   always_comb begin
      d = q;
      d.done = 1'b0;
      if (start) begin
         d.div = 8'h00;
         d.cnt = load_us;
         d.run = 1'b1;
      end else if (q.run) begin
         if (q.div == DIV_LAST) begin
            d.div = 8'h00;
            if (q.cnt <= TMR_W'(1)) begin
               d.cnt = '0;
               d.run = 1'b0;
               d.done = 1'b1;
            end else begin
               d.cnt = q.cnt - TMR_W'(1);
            end
         end else begin
            d.div = q.div + 8'h01;
         end
      end
   end

   // State register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done = q.done;
   assign running = q.run;

endmodule

// ### hdl/nvsram_host.sv
// Host-side controller that drives a byte-wide nonvolatile SRAM over its
// asynchronous pins: plain reads and writes, six-read store and recall
// sequences, and the waits around power loss and power-up reload.
// Assumes device inputs are synchronous to mclk and power_good is a clean level.
`timescale 1ns/1ps

// Functional notes
// R01: Six reads start store or recall
// R02: Sequence addresses issued strictly in order
// R03: Write enable high through all six
// R04: Sixth read leaves data bus undriven
// R05: Wait 550 us reload after power
// R06: Access in progress finishes before store
// R07: Write enable low before chip enable
// R08: Address changes only with chip enable high
// R09: Intervening access aborts the sequence
// R10: Device busy for whole store duration
// R11: Power-down store only if written since
// R12: Recall overwrites SRAM, keeps nonvolatile copy
// R13: Busy interval counted by microsecond timer
// R14: Three-bit step index tracks the sequence
module nvsram_host #(
   parameter int NV_SAVE_US = nvsram_host_pkg::NV_SAVE_DURATION_US,
   parameter int RELOAD_US = nvsram_host_pkg::POWERUP_RELOAD_DURATION_US
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Supply sense: high while supply is above the trigger level
   input wire logic power_good,
   // User request port
   input wire logic req_valid,
   input wire nvsram_host_pkg::req_t req,
   output logic req_ready,
   // User answer port
   output logic rsp_valid,
   output logic [nvsram_host_pkg::DATA_W-1:0] rsp_rdata,
   output logic busy,
   output logic nv_dirty,
   // Memory pins
   output nvsram_host_pkg::pin_t pin,
   output logic [nvsram_host_pkg::DATA_W-1:0] data_bus_o,
   output logic data_bus_oe_n,
   input wire logic [nvsram_host_pkg::DATA_W-1:0] data_bus_i
);

   typedef struct packed {
      nvsram_host_pkg::state_t st;
      nvsram_host_pkg::pin_t pin;
      logic [nvsram_host_pkg::DATA_W-1:0] dout;
      logic dout_oe_n;
      logic [1:0] strb;
      logic [2:0] step;
      logic seq;
      logic recall;
      nvsram_host_pkg::op_t op;
      logic ready;
      logic rsp_v;
      logic [nvsram_host_pkg::DATA_W-1:0] rdata;
      logic busy;
      logic dirty;
      logic tmr_go;
      logic [nvsram_host_pkg::TMR_W-1:0] tmr_us;
   } host_st_t;

   localparam logic [nvsram_host_pkg::TMR_W-1:0] SAVE_LOAD = nvsram_host_pkg::TMR_W'(NV_SAVE_US);
   localparam logic [nvsram_host_pkg::TMR_W-1:0] RELOAD_LOAD = nvsram_host_pkg::TMR_W'(RELOAD_US);

   host_st_t q, d;
   logic tmr_done;

   // Address of a sequence step; the sixth picks store or recall
   function automatic logic [nvsram_host_pkg::ADDR_W-1:0] seq_addr(input logic [2:0] step,
                                                                   input logic recall);
      logic [nvsram_host_pkg::ADDR_W-1:0] a;
      a = nvsram_host_pkg::SEQ_A0;
      case (step)
         3'h1: a = nvsram_host_pkg::SEQ_A1;
         3'h2: a = nvsram_host_pkg::SEQ_A2;
         3'h3: a = nvsram_host_pkg::SEQ_A3;
         3'h4: a = nvsram_host_pkg::SEQ_A4;
         3'h5: a = recall ? nvsram_host_pkg::SEQ_RECALL : nvsram_host_pkg::SEQ_STORE;
         default: a = nvsram_host_pkg::SEQ_A0;
      endcase
      return a;
   endfunction

   // Long waits run on a microsecond tick rather than a wide cycle counter
   us_timer #(
      .CYC_PER_US(nvsram_host_pkg::CYC_PER_US),
      .TMR_W(nvsram_host_pkg::TMR_W)
   ) u_timer (
      .mclk(mclk),
      .rstn(rstn),
      .start(q.tmr_go),
      .load_us(q.tmr_us),
      .done(tmr_done),
      .running()
   );

   // Next-state logic for the whole controller
   always_comb begin
      d = q;
      d.rsp_v = 1'b0;
      d.tmr_go = 1'b0;
      case (q.st)
         // Supply low: all strobes parked high, any sequence is lost
         nvsram_host_pkg::ST_PWR_OFF: begin
            d.pin = nvsram_host_pkg::PIN_IDLE;
            d.dout_oe_n = 1'b1;
            d.seq = 1'b0;
            if (power_good) begin
               d.tmr_go = 1'b1;
               d.tmr_us = RELOAD_LOAD; // see R05
               d.st = nvsram_host_pkg::ST_PWR_UP;
            end
         end
         // Device reloads its array; no access until the reload time ends
         nvsram_host_pkg::ST_PWR_UP: begin
            if (!power_good) begin
               d.st = nvsram_host_pkg::ST_PWR_OFF;
            end else if (tmr_done && !q.tmr_go) begin // Stale done of a cut wait is ignored
               d.st = nvsram_host_pkg::ST_IDLE; // see R05
               d.dirty = 1'b0; // see R12
            end
         end
         nvsram_host_pkg::ST_IDLE: begin
            d.pin.we_n = 1'b1;
            d.pin.oe_n = 1'b1;
            d.dout_oe_n = 1'b1;
            if (!power_good) begin
               d.st = nvsram_host_pkg::ST_PWR_OFF; // see R09
            end else if (q.seq) begin
               // Next step follows at once, nothing else can slip in
               d.pin.addr_bus = seq_addr(q.step, q.recall); // see R02
               d.st = nvsram_host_pkg::ST_SETUP;
            end else if (req_valid && q.ready) begin
               d.op = req.op;
               d.st = nvsram_host_pkg::ST_SETUP;
               if (req.op == nvsram_host_pkg::OP_STORE || req.op == nvsram_host_pkg::OP_RECALL) begin
                  d.seq = 1'b1;
                  d.step = 3'h0; // see R14
                  d.recall = (req.op == nvsram_host_pkg::OP_RECALL);
                  d.pin.addr_bus = seq_addr(3'h0, req.op == nvsram_host_pkg::OP_RECALL); // see R01
               end else begin
                  d.pin.addr_bus = req.addr; // see R08
                  if (req.op == nvsram_host_pkg::OP_WRITE) begin
                     d.pin.we_n = 1'b0; // see R07
                     d.dout = req.wdata;
                     d.dout_oe_n = 1'b0;
                  end
               end
            end
         end
         // Chip enable falls with address and write enable already settled
         nvsram_host_pkg::ST_SETUP: begin
            d.pin.ce_n = 1'b0;
            d.strb = nvsram_host_pkg::STROBE_LAST;
            // Output enable stays high in the sequence: no fight on the last read
            d.pin.oe_n = !(q.op == nvsram_host_pkg::OP_READ && !q.seq); // see R04
            d.st = nvsram_host_pkg::ST_STROBE;
         end
         nvsram_host_pkg::ST_STROBE: begin
            if (q.strb == 2'h0) begin
               d.pin.ce_n = 1'b1;
               d.pin.oe_n = 1'b1;
               d.st = nvsram_host_pkg::ST_RECOVER;
               if (!q.seq) begin
                  d.rsp_v = 1'b1;
                  if (q.op == nvsram_host_pkg::OP_READ) begin
                     d.rdata = data_bus_i;
                  end else begin
                     d.dirty = 1'b1; // see R11
                  end
               end
            end else begin
               d.strb = q.strb - 2'h1;
            end
         end
         // Chip enable high again; write enable and data let go safely
         nvsram_host_pkg::ST_RECOVER: begin
            d.pin.we_n = 1'b1; // see R03
            d.dout_oe_n = 1'b1;
            d.st = nvsram_host_pkg::ST_IDLE;
            if (q.seq) begin
               if (q.step == nvsram_host_pkg::SEQ_LAST) begin
                  d.seq = 1'b0;
                  d.tmr_go = 1'b1;
                  d.tmr_us = q.recall ? nvsram_host_pkg::RECALL_US : SAVE_LOAD; // see R13
                  d.st = nvsram_host_pkg::ST_NVWAIT;
               end else begin
                  d.step = q.step + 3'h1; // see R14
               end
            end
         end
         // Device ignores its pins; hold everything idle until it is done
         nvsram_host_pkg::ST_NVWAIT: begin
            if (!power_good) begin
               d.st = nvsram_host_pkg::ST_PWR_OFF;
            end else if (tmr_done && !q.tmr_go) begin
               d.st = nvsram_host_pkg::ST_IDLE; // see R10
               d.dirty = 1'b0; // see R11
               d.rsp_v = 1'b1;
            end
         end
         default: begin
            d.st = nvsram_host_pkg::ST_PWR_OFF;
         end
      endcase
      // Strobes are a few cycles, well inside the grace time on power loss
      d.ready = (d.st == nvsram_host_pkg::ST_IDLE) && !d.seq && power_good; // see R06
      d.busy = d.seq || (d.st == nvsram_host_pkg::ST_NVWAIT) ||
               (d.st == nvsram_host_pkg::ST_PWR_OFF) || (d.st == nvsram_host_pkg::ST_PWR_UP);
   end

   // State register; reset assumes the device may still be reloading
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         q <= '{st: nvsram_host_pkg::ST_PWR_OFF, pin: nvsram_host_pkg::PIN_IDLE,
                dout: 8'h00, dout_oe_n: 1'b1, strb: 2'h0, step: 3'h0, seq: 1'b0,
                recall: 1'b0, op: nvsram_host_pkg::OP_READ, ready: 1'b0, rsp_v: 1'b0,
                rdata: nvsram_host_pkg::RDATA_RST, busy: 1'b1, dirty: 1'b0,
                tmr_go: 1'b0, tmr_us: 16'h0000};
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign req_ready = q.ready;
   assign rsp_valid = q.rsp_v;
   assign rsp_rdata = q.rdata;
   assign busy = q.busy;
   assign nv_dirty = q.dirty;
   assign pin = q.pin;
   assign data_bus_o = q.dout;
   assign data_bus_oe_n = q.dout_oe_n;

endmodule

// ### dv/nvsram_host_assertions.sv
// Port-level checks on the host controller for the nonvolatile SRAM.
// Assumes it is bound into nvsram_host and sees only that module's ports.
`timescale 1ns/1ps

module nvsram_host_assertions #(
   parameter int RELOAD_US = 2
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // User side
   input wire logic power_good,
   input wire logic req_valid,
   input wire nvsram_host_pkg::req_t req,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire logic [nvsram_host_pkg::DATA_W-1:0] rsp_rdata,
   input wire logic busy,
   input wire logic nv_dirty,
   // Memory side
   input wire nvsram_host_pkg::pin_t pin,
   input wire logic data_bus_oe_n,
   input wire logic [nvsram_host_pkg::DATA_W-1:0] data_bus_i
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   localparam int RELOAD_CYC = RELOAD_US * nvsram_host_pkg::CYC_PER_US;
   logic take_rd;
   logic take_wr;
   logic take_nv;
   logic [15:0] pg_cnt_q;

   // Taken requests by kind; op bit 1 marks store and recall
   assign take_rd = req_valid && req_ready && req.op == nvsram_host_pkg::OP_READ;
   assign take_wr = req_valid && req_ready && req.op == nvsram_host_pkg::OP_WRITE;
   assign take_nv = req_valid && req_ready && req.op[1];

   // Cycles of steady supply; saturates so a long run cannot wrap it
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn || !power_good) begin
         pg_cnt_q <= 16'h0000;
      end else if (pg_cnt_q != 16'hFFFF) begin
         pg_cnt_q <= pg_cnt_q + 16'h0001;
      end
   end

   a_addr_only_idle: assert property ($changed(pin.addr_bus) |-> pin.ce_n)
      else $error("address moved with chip enable low");
   a_strobe_two_cyc: assert property ($fell(pin.ce_n) |-> ##1 !pin.ce_n ##1 pin.ce_n)
      else $error("chip enable pulse not two cycles");
   a_read_answer: assert property (take_rd |-> ##4 rsp_valid && rsp_rdata == $past(data_bus_i))
      else $error("read answer late or wrong");
   a_we_lead_ce: assert property ($fell(pin.ce_n) && !pin.we_n |-> $past(!pin.we_n) && !data_bus_oe_n)
      else $error("write enable not ahead of chip enable");
   a_seq_we_high: assert property (take_nv |-> ##1 (pin.we_n && data_bus_oe_n)[*8])
      else $error("write enable low in sequence");
   a_seq_first_addr: assert property (take_nv |-> ##[1:3] !pin.ce_n && pin.addr_bus == 13'h0000)
      else $error("sequence does not open at zero");
   a_busy_blocks: assert property (busy |-> !req_ready)
      else $error("ready while busy");
   a_power_loss: assert property ($fell(power_good) |-> ##[1:6] busy && pin.ce_n)
      else $error("no stop after power loss");
   a_reload_wait: assert property (req_ready |-> pg_cnt_q >= RELOAD_CYC)
      else $error("ready before reload time");
   a_write_dirty: assert property (take_wr |-> ##4 rsp_valid && nv_dirty)
      else $error("write not marked dirty");

   c_store: cover property (take_nv && req.op == nvsram_host_pkg::OP_STORE);
   c_recall: cover property (take_nv && req.op == nvsram_host_pkg::OP_RECALL);
   c_power_loss: cover property ($fell(power_good));
endmodule

bind nvsram_host nvsram_host_assertions #(.RELOAD_US(RELOAD_US)) chk (
   .mclk(mclk), .rstn(rstn), .power_good(power_good), .req_valid(req_valid), .req(req),
   .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy),
   .nv_dirty(nv_dirty), .pin(pin), .data_bus_oe_n(data_bus_oe_n), .data_bus_i(data_bus_i));

// ### dv/nvsram_dev_model.sv
// Behavioural model of the nonvolatile SRAM seen by the host controller.
// Assumes strobes are synchronous to mclk; busy times count mclk cycles.
`timescale 1ns/1ps

module nvsram_dev_model #(
   parameter int STORE_CYC = 100,
   parameter int RECALL_CYC = 700,
   parameter int RELOAD_CYC = 60
) (
   // Clock and supply
   input wire logic mclk,
   input wire logic power_good,
   // Pins from the host
   input wire nvsram_host_pkg::pin_t pin,
   input wire logic [7:0] data_bus_o,
   input wire logic data_bus_oe_n,
   // Data towards the host
   output logic [7:0] data_bus_i
);
   localparam logic [12:0] SEQ [5] = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
   logic [7:0] sram [0:8191];
   logic [7:0] nv [0:8191] = '{default: 8'h00};
   logic [2:0] step_q = 3'h0;
   logic written_q = 1'b0;
   logic ce_q = 1'b1;
   logic up_q = 1'b0;
   logic drive;
   logic [7:0] last_q = 8'h00;
   int busy_q = 0;
   int sw_stores = 0;
   int auto_stores = 0;

   // A released bus shows the inverse of the last byte, never a stale copy
   assign drive = !pin.ce_n && !pin.oe_n && pin.we_n && busy_q == 0 && up_q;
   assign data_bus_i = drive ? sram[pin.addr_bus] : ~last_q;

   // Accesses are taken on the falling chip enable
   always @(posedge mclk) begin
      ce_q <= pin.ce_n;
      if (drive) begin
         last_q <= data_bus_i;
      end
      if (!power_good) begin
         if (up_q && written_q) begin
            nv <= sram;
            auto_stores <= auto_stores + 1;
         end
         written_q <= 1'b0;
         up_q <= 1'b0;
         step_q <= 3'h0;
         busy_q <= 0;
      end else if (!up_q) begin
         // Clear then load collapses to one copy in this model
         sram <= nv;
         up_q <= 1'b1;
         busy_q <= RELOAD_CYC;
      end else if (busy_q != 0) begin
         busy_q <= busy_q - 1;
      end else if (ce_q && !pin.ce_n) begin
         // A bus the host does not drive stores garbage, so read back exposes it
         if (!pin.we_n) begin
            sram[pin.addr_bus] <= data_bus_oe_n ? ~data_bus_o : data_bus_o;
            written_q <= 1'b1;
            step_q <= 3'h0;
         end else if (step_q == 3'h5 && pin.addr_bus[12:1] == 12'h787) begin
            if (pin.addr_bus[0]) begin
               nv <= sram;
               sw_stores <= sw_stores + 1;
            end else begin
               sram <= nv;
            end
            written_q <= 1'b0;
            step_q <= 3'h0;
            busy_q <= pin.addr_bus[0] ? STORE_CYC : RECALL_CYC;
         end else if (step_q != 3'h5 && pin.addr_bus == SEQ[step_q]) begin
            step_q <= step_q + 3'h1;
         end else begin
            step_q <= {2'b00, pin.addr_bus == 13'h0000};
         end
      end
   end
endmodule

// ### dv/nvsram_host_test.sv
// Self-checking bench: host controller driving the device model.
// Assumes store and reload times shortened through the parameters below.
`timescale 1ns/1ps

module nvsram_host_test;
   localparam int NV_US = 3;
   localparam int CPU = nvsram_host_pkg::CYC_PER_US;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic power_good = 1'b0;
   logic req_valid = 1'b0;
   nvsram_host_pkg::req_t req = '0;
   logic req_ready;
   logic rsp_valid;
   logic busy;
   logic nv_dirty;
   logic [7:0] rsp_rdata;
   logic [7:0] data_bus_o;
   logic [7:0] data_bus_i;
   logic data_bus_oe_n;
   nvsram_host_pkg::pin_t pin;
   int mismatches = 0;
   int checks = 0;
   int lat;

   always #12.5 mclk = ~mclk;

   nvsram_host #(.NV_SAVE_US(NV_US), .RELOAD_US(2)) uut (.mclk(mclk), .rstn(rstn),
      .power_good(power_good), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy), .nv_dirty(nv_dirty),
      .pin(pin), .data_bus_o(data_bus_o), .data_bus_oe_n(data_bus_oe_n),
      .data_bus_i(data_bus_i));
   nvsram_dev_model dev (.mclk(mclk), .power_good(power_good), .pin(pin),
      .data_bus_o(data_bus_o), .data_bus_oe_n(data_bus_oe_n), .data_bus_i(data_bus_i));

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Waits up to n cycles for ready, sampled mid-cycle
   task automatic wait_ready(input int n);
      while (req_ready !== 1'b1 && n > 0) begin
         @(negedge mclk);
         n--;
      end
   endtask

   // One request; lat counts cycles from the taking edge to the answer
   task automatic issue(input nvsram_host_pkg::op_t op, input logic [12:0] a, input logic [7:0] d);
      req_valid = 1'b1;
      req = '{op: op, addr: a, wdata: d};
      wait_ready(2000);
      @(negedge mclk);
      req_valid = 1'b0;
      lat = 1;
      while (rsp_valid !== 1'b1 && lat < 2000) begin
         @(negedge mclk);
         lat++;
      end
   endtask

   task automatic t_powerup();
      check("busy at power off", 1, busy);
      power_good = 1'b1;
      for (int i = 0; i < 80; i++) begin
         @(negedge mclk);
         check("ready during reload", 0, req_ready);
      end
      wait_ready(20);
      check("ready after reload", 1, req_ready);
      $display("powerup test done");
   endtask

   task automatic t_access();
      issue(nvsram_host_pkg::OP_WRITE, 13'h0123, 8'hA5);
      check("dirty after write", 1, nv_dirty);
      check("write drives bus", 0, data_bus_oe_n);
      issue(nvsram_host_pkg::OP_READ, 13'h0123, 8'h00);
      check("read latency", 4, lat);
      check("read data", 8'hA5, rsp_rdata);
      check("read leaves bus", 1, data_bus_oe_n);
      issue(nvsram_host_pkg::OP_STORE, 13'h0000, 8'h00);
      check("store wait", 1, lat >= 30 + NV_US * CPU && lat < 160);
      check("saved byte", 8'hA5, dev.nv[13'h0123]);
      check("software stores", 1, dev.sw_stores);
      @(negedge mclk);
      check("dirty after store", 0, nv_dirty);
      issue(nvsram_host_pkg::OP_WRITE, 13'h0123, 8'h3C);
      issue(nvsram_host_pkg::OP_RECALL, 13'h0000, 8'h00);
      check("recall wait", 1, lat >= 30 + 20 * CPU && lat < 840);
      issue(nvsram_host_pkg::OP_READ, 13'h0123, 8'h00);
      check("recalled byte", 8'hA5, rsp_rdata);
      check("copy kept", 8'hA5, dev.nv[13'h0123]);
      $display("access test done");
   endtask

   task automatic t_power_loss();
      int seen;
      seen = 0;
      issue(nvsram_host_pkg::OP_WRITE, 13'h0200, 8'h77);
      req_valid = 1'b1;
      req.op = nvsram_host_pkg::OP_STORE;
      wait_ready(20);
      @(negedge mclk);
      req_valid = 1'b0;
      repeat (10) @(negedge mclk);
      power_good = 1'b0;
      for (int i = 0; i < 200; i++) begin
         @(negedge mclk);
         seen += rsp_valid;
      end
      check("answers after loss", 0, seen);
      check("auto stores", 1, dev.auto_stores);
      check("software stores", 1, dev.sw_stores);
      power_good = 1'b1;
      issue(nvsram_host_pkg::OP_READ, 13'h0200, 8'h00);
      check("reloaded byte", 8'h77, rsp_rdata);
      check("dirty after reload", 0, nv_dirty);
      power_good = 1'b0;
      repeat (20) @(negedge mclk);
      check("clean auto stores", 1, dev.auto_stores);
      $display("power loss test done");
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Whole run is under two thousand cycles; this margin only catches hangs
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      $display("[FAIL] run length expected finish seen timeout");
      conclude();
   end

   initial begin
      repeat (8) @(negedge mclk);
      rstn = 1'b1;
      @(negedge mclk);
      t_powerup();
      t_access();
      t_power_loss();
      conclude();
   end
endmodule
